// File: rtl/smi_pkg.sv
package smi_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS   = 4;
	localparam int SLEEP_ENTRY_NS  = 100000;
	localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_MAX_NS     = 10000000;
	localparam int WAKE_MAX_CYC    = WAKE_MAX_NS / CLK_PERIOD_NS;
	localparam int CNT_W           = 22;

	// Register map, byte addresses
	localparam logic [11:0] ADDR_CTRL       = 12'h000;
	localparam logic [11:0] ADDR_STATUS     = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
	localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h00c;
	localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h010;

	// Control fields
	localparam int          CTRL_STEP_HOLD_BIT = 0;
	localparam logic        CTRL_RESET         = 1'h0;

	// Status fields
	localparam int STAT_INDEX_LSB  = 0;
	localparam int STAT_STATE_LSB  = 8;
	localparam int STAT_FAULT_BIT  = 10;
	localparam int STAT_MODE_LSB   = 11;
	localparam int STAT_BRIDGE_BIT = 14;

	// Interrupt events
	localparam int          IRQ_W         = 4;
	localparam int          EV_STEP       = 0;
	localparam int          EV_FAULT      = 1;
	localparam int          EV_SLEEP      = 2;
	localparam int          EV_WAKE       = 3;
	localparam logic [3:0]  IRQ_RESET     = 4'h0;

	// Angle table
	localparam int          IDX_W         = 7;
	localparam logic [6:0]  IDX_RESET     = 7'h00;
	localparam logic [6:0]  FULL_OFFSET   = 7'h10;
	localparam logic [4:0]  DIAG_POS      = 5'h10;
	localparam logic [6:0]  PCT_FULL      = 7'h64;
	localparam logic [6:0]  PCT_FULL_INIT = 7'h46;

	// Resolution codes, {bit0, bit1, bit2}
	typedef enum logic [2:0]
	{
		RES_FULL    = 3'b000,
		RES_HALF_A  = 3'b001,
		RES_HALF_B  = 3'b010,
		RES_QUARTER = 3'b011,
		RES_EIGHTH  = 3'b100,
		RES_SIXTEEN = 3'b101,
		RES_32_A    = 3'b110,
		RES_32_B    = 3'b111
	} smi_res_e;

	typedef enum logic [1:0]
	{
		ST_RUN   = 2'b00,
		ST_ENTER = 2'b01,
		ST_SLEEP = 2'b10,
		ST_WAKE  = 2'b11
	} smi_state_e;

endpackage

// File: rtl/smi_sine_rom.sv
`timescale 1ns/1ps
module smi_sine_rom
	import smi_pkg::*;
(
	input  wire logic [5:0] k,
	output logic      [6:0] mag
);

	// Cosine magnitude in percent over a quarter cycle, k in 0..32
	always_comb
	begin
		unique case (k)
			6'h00, 6'h01, 6'h02: mag = 7'h64;
			6'h03: mag = 7'h63;
			6'h04: mag = 7'h62;
			6'h05: mag = 7'h61;
			6'h06: mag = 7'h60;
			6'h07: mag = 7'h5e;
			6'h08: mag = 7'h5c;
			6'h09: mag = 7'h5a;
			6'h0a: mag = 7'h58;
			6'h0b: mag = 7'h56;
			6'h0c: mag = 7'h53;
			6'h0d: mag = 7'h50;
			6'h0e: mag = 7'h4d;
			6'h0f: mag = 7'h4a;
			6'h10: mag = 7'h47;
			6'h11: mag = 7'h43;
			6'h12: mag = 7'h3f;
			6'h13: mag = 7'h3c;
			6'h14: mag = 7'h38;
			6'h15: mag = 7'h33;
			6'h16: mag = 7'h2f;
			6'h17: mag = 7'h2b;
			6'h18: mag = 7'h26;
			6'h19: mag = 7'h22;
			6'h1a: mag = 7'h1d;
			6'h1b: mag = 7'h18;
			6'h1c: mag = 7'h14;
			6'h1d: mag = 7'h0f;
			6'h1e: mag = 7'h0a;
			6'h1f: mag = 7'h05;
			default: mag = 7'h00;
		endcase
	end

endmodule

// File: rtl/smi_indexer.sv
`timescale 1ns/1ps
// Operation
// RULE_01: Fault shutdown held until sleep cycle
// RULE_02: Sleep entered 100 us after input low
// RULE_03: Normal operation within 10 ms after wake
// RULE_04: Sleep stops charge pump and regulator
// RULE_05: Step rising edge advances the angle
// RULE_06: Step falling edge holds position
// RULE_07: Enable high turns bridge on
// RULE_08: Enable low turns bridge off
// RULE_09: Direction high forward, low reverse
// RULE_10: Codes 000, 001, 010 full, half a, half b
// RULE_11: Codes 011, 100, 101 quarter, eighth, sixteenth
// RULE_12: Codes 110 and 111 select 1/32
// RULE_13: Index maps to sine/cosine current table
// RULE_14: Full and half a diagonals at 100
// RULE_15: Step size 32 over denominator, wraps
// RULE_16: Host holds inputs stable, no sleep steps
module smi_indexer
	import smi_pkg::*;
#(
	parameter int SLEEP_CYC = SLEEP_ENTRY_CYC,
	parameter int WAKE_CYC  = WAKE_MAX_CYC
)
(
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        SLEEP_N,
	input  wire logic        STEP_CLK,
	input  wire logic        OUTPUT_ENABLE,
	input  wire logic        ROTATION_DIRECTION,
	input  wire logic        RESOLUTION_SEL_BIT0,
	input  wire logic        RESOLUTION_SEL_BIT1,
	input  wire logic        RESOLUTION_SEL_BIT2,
	input  wire logic        OVERTEMP_SHUTDOWN,
	input  wire logic        OVERCURRENT_SHUTDOWN,
	output logic      [7:0]  PHASE_A_PCT,
	output logic      [7:0]  PHASE_B_PCT,
	output logic      [6:0]  ANGLE_INDEX,
	output logic             BRIDGE_ON,
	output logic             CHARGE_PUMP_ON,
	output logic             LOGIC_REG_ON,
	output logic             IRQ
);

	////////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [6:0] step_size(input smi_res_e m);
		unique case (m)
			RES_FULL:             step_size = 7'h20;
			RES_HALF_A, RES_HALF_B: step_size = 7'h10;
			RES_QUARTER:          step_size = 7'h08;
			RES_EIGHTH:           step_size = 7'h04;
			RES_SIXTEEN:          step_size = 7'h02;
			RES_32_A, RES_32_B:   step_size = 7'h01;
		endcase
	endfunction

	// Off-grid positions snap onto the grid first, so the first step after a mode change never
	// leaves the index between table entries of the new resolution.
	function automatic logic [6:0] next_index(input logic [6:0] idx, input logic [6:0] s,
		input logic fwd, input logic [6:0] off);
		logic [6:0] rel;
		logic [6:0] base;
		rel  = 7'(idx - off);
		base = rel & ~7'(s - 7'h01);
		if (fwd)
			next_index = 7'(base + s + off);
		else if (base == rel)
			next_index = 7'(base - s + off);
		else
			next_index = 7'(base + off);
	endfunction

	function automatic logic [7:0] signed_pct(input logic [6:0] m, input logic neg);
		signed_pct = neg ? 8'(8'h00 - {1'b0, m}) : {1'b0, m};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	smi_state_e       state;
	logic [CNT_W-1:0] cnt;
	logic             fault;
	logic             step_prev;
	logic [6:0]       idx;
	logic             step_hold;
	logic [3:0]       irq_status;
	logic [3:0]       irq_enable;

	////////////////////////////////////////////////////////////////////////////
	// Decode

	wire smi_res_e mode = smi_res_e'({RESOLUTION_SEL_BIT0, RESOLUTION_SEL_BIT1,
		RESOLUTION_SEL_BIT2}); // RULE_10 RULE_11 RULE_12
	wire       active     = (state == ST_RUN) || (state == ST_ENTER);
	wire       step_rise  = STEP_CLK && !step_prev; // RULE_05 RULE_06
	wire       step_take  = step_rise && active && !step_hold;
	wire       fault_in   = OVERTEMP_SHUTDOWN || OVERCURRENT_SHUTDOWN;
	wire       diag_mode  = (mode == RES_FULL) || (mode == RES_HALF_A);
	wire [6:0] grid_off   = (mode == RES_FULL) ? FULL_OFFSET : IDX_RESET;
	wire [6:0] next_idx   = step_take ? next_index(idx, step_size(mode), ROTATION_DIRECTION,
		grid_off) : idx; // RULE_09 RULE_15
	wire       ent_done   = (state == ST_ENTER) && (cnt == CNT_W'(SLEEP_CYC - 1));
	wire       wake_done  = (state == ST_WAKE) && (cnt == CNT_W'(WAKE_CYC - 1));

	////////////////////////////////////////////////////////////////////////////
	// Sleep sequencer

	smi_state_e       next_state;
	logic [CNT_W-1:0] next_cnt;

	always_comb
	begin
		next_state = state;
		next_cnt   = 22'h000000;
		unique case (state)
			ST_RUN:
				if (!SLEEP_N)
					next_state = ST_ENTER;
			ST_ENTER:
				if (SLEEP_N)
					next_state = ST_RUN;
				else if (ent_done)
					next_state = ST_SLEEP; // RULE_02
				else
					next_cnt = CNT_W'(cnt + 1'b1);
			ST_SLEEP:
				if (SLEEP_N)
					next_state = ST_WAKE;
			ST_WAKE:
				if (!SLEEP_N)
					next_state = ST_ENTER;
				else if (wake_done)
					next_state = ST_RUN; // RULE_03
				else
					next_cnt = CNT_W'(cnt + 1'b1);
		endcase
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			state <= ST_RUN;
			cnt   <= 22'h000000;
		end
		else
		begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	// New detector trips win over the release in sleep
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
			fault <= 1'b0;
		else
			fault <= (fault && (state != ST_SLEEP)) || fault_in; // RULE_01
	end

	////////////////////////////////////////////////////////////////////////////
	// Indexer and current table

	logic [4:0] r;
	logic [1:0] q;
	logic [6:0] mag_a;
	logic [6:0] mag_b;

	assign r = idx[4:0];
	assign q = idx[6:5];

	wire [5:0] k_a = q[0] ? 6'(6'h20 - {1'b0, r}) : {1'b0, r};
	wire [5:0] k_b = q[0] ? {1'b0, r} : 6'(6'h20 - {1'b0, r});

	smi_sine_rom u_rom_a
	(
		.k   (k_a),
		.mag (mag_a)
	);

	smi_sine_rom u_rom_b
	(
		.k   (k_b),
		.mag (mag_b)
	);

	wire       at_diag   = diag_mode && (r == DIAG_POS); // RULE_14
	wire       full_init = (mode == RES_FULL) && (idx == IDX_RESET); // RULE_14
	wire [6:0] eff_a     = full_init ? PCT_FULL_INIT : (at_diag ? PCT_FULL : mag_a);
	wire [6:0] eff_b     = full_init ? PCT_FULL_INIT : (at_diag ? PCT_FULL : mag_b);
	wire       neg_a     = !full_init && (q[1] ^ q[0]);
	wire       neg_b     = !full_init && q[1];
	wire [7:0] next_a    = signed_pct(eff_a, neg_a); // RULE_13
	wire [7:0] next_b    = signed_pct(eff_b, neg_b); // RULE_13

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			idx       <= IDX_RESET;
			step_prev <= 1'b0;
		end
		else
		begin
			idx       <= next_idx; // RULE_05
			step_prev <= STEP_CLK;
		end
	end

	// Table look-up is one cycle behind the index
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			PHASE_A_PCT    <= 8'h00;
			PHASE_B_PCT    <= 8'h00;
			ANGLE_INDEX    <= IDX_RESET;
			BRIDGE_ON      <= 1'b0;
			CHARGE_PUMP_ON <= 1'b1;
			LOGIC_REG_ON   <= 1'b1;
		end
		else
		begin
			PHASE_A_PCT    <= next_a;
			PHASE_B_PCT    <= next_b;
			ANGLE_INDEX    <= idx;
			BRIDGE_ON      <= OUTPUT_ENABLE && active && !fault && !fault_in; // RULE_07 RULE_08
			CHARGE_PUMP_ON <= (next_state != ST_SLEEP); // RULE_04
			LOGIC_REG_ON   <= (next_state != ST_SLEEP); // RULE_04
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB slave, one wait state on every access

	wire        acc_req   = PSEL && PENABLE && !PREADY;
	wire        commit    = PSEL && PENABLE && PREADY;
	wire        wr_commit = commit && PWRITE;
	wire        hit_ctrl  = (PADDR == ADDR_CTRL);
	wire        hit_stat  = (PADDR == ADDR_STATUS);
	wire        hit_ists  = (PADDR == ADDR_IRQ_STATUS);
	wire        hit_iclr  = (PADDR == ADDR_IRQ_CLEAR);
	wire        hit_ien   = (PADDR == ADDR_IRQ_ENABLE);
	wire        mapped    = hit_ctrl || hit_stat || hit_ists || hit_iclr || hit_ien;
	wire [31:0] status_word = ({25'h0000000, idx} << STAT_INDEX_LSB)
		| ({30'h00000000, state} << STAT_STATE_LSB)
		| ({31'h00000000, fault} << STAT_FAULT_BIT)
		| ({29'h00000000, mode} << STAT_MODE_LSB)
		| ({31'h00000000, BRIDGE_ON} << STAT_BRIDGE_BIT);
	wire [31:0] rd_mux = hit_ctrl ? {31'h00000000, step_hold}
		: hit_stat ? status_word
		: hit_ists ? {28'h0000000, irq_status}
		: hit_ien  ? {28'h0000000, irq_enable}
		: 32'h00000000;

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end
		else
		begin
			PREADY  <= acc_req;
			PSLVERR <= acc_req && !mapped;
			PRDATA  <= (acc_req && !PWRITE) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			step_hold  <= CTRL_RESET;
			irq_enable <= IRQ_RESET;
		end
		else
		begin
			if (wr_commit && hit_ctrl)
				step_hold <= PWDATA[CTRL_STEP_HOLD_BIT];
			if (wr_commit && hit_ien)
				irq_enable <= PWDATA[IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupts, a new event wins over a clear in the same cycle

	wire [3:0] events = {wake_done, ent_done, fault_in && !fault, step_take};
	wire [3:0] clr    = (wr_commit && hit_iclr) ? PWDATA[IRQ_W-1:0] : 4'h0;
	wire [3:0] next_irq_status = (irq_status & ~clr) | events;

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			irq_status <= IRQ_RESET;
			IRQ        <= 1'b0;
		end
		else
		begin
			irq_status <= next_irq_status;
			IRQ        <= |(next_irq_status & irq_enable);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	a_fault_off: assert property (fault |=> !BRIDGE_ON) // RULE_01
		else $error("bridge on while fault latched");
	a_fault_release: assert property ((state == ST_SLEEP) && !fault_in |=> !fault) // RULE_01
		else $error("fault not released by sleep");
	a_sleep_entry: assert property (ent_done && !SLEEP_N |=> state == ST_SLEEP) // RULE_02
		else $error("sleep not entered at delay end");
	a_wake_bound: assert property ((state == ST_WAKE) |-> cnt < CNT_W'(WAKE_CYC)) // RULE_03
		else $error("wake interval overrun");
	a_sleep_supply: assert property ((state == ST_SLEEP) && !SLEEP_N // RULE_04
		|=> !CHARGE_PUMP_ON && !LOGIC_REG_ON)
		else $error("supplies on in sleep");
	a_step_moves: assert property (step_take |=> idx != $past(idx)) // RULE_05
		else $error("step edge did not advance");
	a_fall_holds: assert property (!step_rise |=> idx == $past(idx)) // RULE_06
		else $error("index moved without rising edge");
	a_enable_on: assert property (OUTPUT_ENABLE && active && !fault && !fault_in // RULE_07
		|=> BRIDGE_ON)
		else $error("bridge not on when enabled");
	a_enable_off: assert property (!OUTPUT_ENABLE |=> !BRIDGE_ON) // RULE_08
		else $error("bridge on when disabled");
	a_fine_dir: assert property (step_take && (mode == RES_32_B) // RULE_09
		|=> idx == 7'($past(idx) + (ROTATION_DIRECTION ? 7'h01 : 7'h7f)))
		else $error("fine step wrong direction");
	a_mid_table: assert property ((idx == 7'h10) && !diag_mode // RULE_13
		|=> (PHASE_A_PCT == 8'h47) && (PHASE_B_PCT == 8'h47))
		else $error("table midpoint not 71 percent");
	a_diag_full: assert property ((r == DIAG_POS) && (mode == RES_HALF_A) // RULE_14
		|=> PHASE_B_PCT == 8'h64 || PHASE_B_PCT == 8'h9c)
		else $error("diagonal not at full current");
	a_quarter_step: assert property (step_take && (mode == RES_QUARTER) // RULE_15
		&& (idx[2:0] == 3'h0) |=> idx == 7'($past(idx) + (ROTATION_DIRECTION ? 7'h08 : 7'h78)))
		else $error("quarter step size wrong");

	c_sleep_cycle: cover property ((state == ST_SLEEP) ##1 (state == ST_WAKE));
	c_fault_clear: cover property (fault ##1 (state == ST_SLEEP) ##1 !fault);
	c_reverse_wrap: cover property (step_take && !ROTATION_DIRECTION && (idx == IDX_RESET));
	c_irq_raised: cover property (!IRQ ##1 IRQ);

endmodule

// File: sim/smi_host_model.sv
`timescale 1ns/1ps
// Host pins, moved only just after a clock edge
module smi_host_model
(
	input  wire logic       clk,
	output logic            step_clk,
	output logic            rotation_direction,
	output logic      [2:0] res_code,
	output logic            sleep_n,
	output logic            output_enable
);
	initial
	begin
		step_clk = 1'h0;
		rotation_direction = 1'h1;
		res_code = 3'h0;
		sleep_n = 1'h1;
		output_enable = 1'h0;
	end
	// Mode and direction settle well before the next step edge
	task set_pins(input logic [2:0] code, input logic dir);
		@(posedge clk);
		res_code <= code;
		rotation_direction <= dir;
		repeat (2) @(posedge clk);
	endtask
	// Each step level held four cycles; never called while asleep
	task step_edge(input logic v);
		@(posedge clk);
		step_clk <= v;
		repeat (3) @(posedge clk);
	endtask
	task sleep(input logic v);
		@(posedge clk);
		sleep_n <= v;
	endtask
	task enable(input logic v);
		@(posedge clk);
		output_enable <= v;
		repeat (3) @(posedge clk);
	endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
	import smi_pkg::*;
	logic        clk, srst, psel, penable, pwrite, ot, oc, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	logic [31:0] prdata;
	logic        pready, pslverr, step, dir, slp_n, oe, bridge, cp, lreg, irq;
	logic [2:0]  code;
	logic [7:0]  pa, pb;
	logic [6:0]  idx;
	int          failures, tests_run;
	logic [6:0]  t_idx [8] = '{7'h10, 7'h10, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h01};
	logic [15:0] t_ph [8] = '{16'h6464, 16'h6464, 16'h4747, 16'h5c26, 16'h6214, 16'h640a,
		16'h6405, 16'h6405};

	smi_host_model host_u (.clk(clk), .step_clk(step), .rotation_direction(dir),
		.res_code(code), .sleep_n(slp_n), .output_enable(oe));

	// Short counts keep the sleep and wake walk to a few dozen cycles
	smi_indexer #(.SLEEP_CYC(8), .WAKE_CYC(16)) dut_u (.SYS_CLK(clk), .SRST(srst),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SLEEP_N(slp_n),
		.STEP_CLK(step), .OUTPUT_ENABLE(oe), .ROTATION_DIRECTION(dir),
		.RESOLUTION_SEL_BIT0(code[2]), .RESOLUTION_SEL_BIT1(code[1]),
		.RESOLUTION_SEL_BIT2(code[0]), .OVERTEMP_SHUTDOWN(ot), .OVERCURRENT_SHUTDOWN(oc),
		.PHASE_A_PCT(pa), .PHASE_B_PCT(pb), .ANGLE_INDEX(idx), .BRIDGE_ON(bridge),
		.CHARGE_PUMP_ON(cp), .LOGIC_REG_ON(lreg), .IRQ(irq));

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	task tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held until pready is seen high at a rising edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		// Only the watchdog ends a wait that never sees pready
		do
			@(posedge clk);
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task rst;
		@(posedge clk);
		srst <= 1'h1;
		repeat (12) @(posedge clk);
		srst <= 1'h0;
		repeat (3) @(posedge clk);
	endtask

	task stepw;
		host_u.step_edge(1'h1);
		host_u.step_edge(1'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		srst = 1'h1;
		{psel, penable, pwrite, ot, oc} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		rst();
		chk({bridge, cp, lreg}, 3'h3);
		chk({pa, pb}, 16'h4646);
		for (int m = 0; m < 8; m++)
		begin
			host_u.set_pins(m[2:0], 1'h1);
			rst();
			stepw();
			chk(idx, t_idx[m]);
			chk({pa, pb}, t_ph[m]);
			stepw();
			chk(idx, (m == 0) ? 7'h30 : 7'(2 * t_idx[m]));
			apb(1'h0, ADDR_STATUS, 32'h0);
			chk(rd[13:11], m[2:0]);
		end
		// Reverse from zero wraps to the top of the cycle
		host_u.set_pins(3'h6, 1'h0);
		rst();
		host_u.step_edge(1'h1);
		chk(idx, 7'h7f);
		host_u.step_edge(1'h0);
		chk(idx, 7'h7f);
		apb(1'h1, ADDR_CTRL, 32'h1);
		stepw();
		chk(idx, 7'h7f);
		apb(1'h1, ADDR_CTRL, 32'h0);
		// Old step event cleared so the next irq comes from a new step
		apb(1'h1, ADDR_IRQ_CLEAR, 32'hf);
		apb(1'h0, ADDR_IRQ_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'h1, ADDR_IRQ_ENABLE, 32'h1);
		stepw();
		chk(irq, 1'h1);
		chk(idx, 7'h7e);
		apb(1'h1, ADDR_IRQ_ENABLE, 32'h0);
		repeat (2) @(posedge clk);
		chk(irq, 1'h0);
		apb(1'h1, ADDR_IRQ_ENABLE, 32'h1);
		apb(1'h1, ADDR_IRQ_CLEAR, 32'hf);
		repeat (2) @(posedge clk);
		chk(irq, 1'h0);
		apb(1'h0, 12'h020, 32'h0);
		chk({31'h00000000, err}, 32'h1);
		chk(rd, 32'h0);
		host_u.enable(1'h1);
		chk(bridge, 1'h1);
		host_u.enable(1'h0);
		chk(bridge, 1'h0);
		host_u.enable(1'h1);
		@(posedge clk);
		ot <= 1'h1;
		@(posedge clk);
		ot <= 1'h0;
		oc <= 1'h1;
		@(posedge clk);
		oc <= 1'h0;
		repeat (4) @(posedge clk);
		chk(bridge, 1'h0);
		host_u.sleep(1'h0);
		repeat (4) @(posedge clk);
		chk({cp, lreg}, 2'h3);
		repeat (10) @(posedge clk);
		chk({cp, lreg}, 2'h0);
		host_u.sleep(1'h1);
		repeat (3) @(posedge clk);
		chk({cp, lreg}, 2'h3);
		repeat (20) @(posedge clk);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk(rd[9:8], 2'h0);
		chk(bridge, 1'h1);
		apb(1'h0, ADDR_IRQ_STATUS, 32'h0);
		chk(rd, 32'he);
		stepw();
		chk(idx, 7'h7d);
		tally_and_finish();
	end

	initial
	begin
		#100us;
		failures++;
		tally_and_finish();
	end
endmodule
